// *** src/fcc_pkg.sv ***
// Package for the floppy control command unit: opcodes, codes, timing counts
package fcc_pkg;

  // Clock rate and timing base
  localparam int CLK_HZ = 25000000;
  localparam int MS_US = 1000;
  localparam int HALF_MS_US = 500;
  // Cycles in 0.5 ms at 1 Mbps (shortest base unit rounded down)
  localparam int HALF_MS_CYC = (CLK_HZ / 1000) * HALF_MS_US / MS_US;
  // Step pulse width in microseconds and cycles
  localparam int STEP_PULSE_US = 4;
  localparam int STEP_PULSE_CYC = (CLK_HZ / 1000000) * STEP_PULSE_US;

  // Command opcodes (low five bits of the first byte)
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_SENSE_DRIVE = 5'h04;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SEEK = 5'h0F;
  localparam logic [4:0] OP_VERSION = 5'h10;
  localparam logic [4:0] OP_CONFIGURE = 5'h13;

  // Result constants
  localparam logic [7:0] INVALID_STATUS = 8'h80;
  // Arbitrary neutral identity value, not any real part's code
  localparam logic [7:0] VERSION_DEFAULT = 8'h5A;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLLING = 2'h3;

  // Code defaults and special values
  localparam logic [3:0] UNLOAD_ZERO_UNITS = 4'h0;
  // Code zero stands for 128 ms at 1 Mbps
  localparam logic [8:0] UNLOAD_ZERO_VALUE = 9'h080;
  localparam logic [8:0] LOAD_ZERO_VALUE = 9'h080;
  localparam logic [3:0] STEP_CODE_RESET = 4'h0;
  localparam logic [3:0] UNLOAD_CODE_RESET = 4'h0;
  localparam logic [6:0] LOAD_CODE_RESET = 7'h00;
  localparam logic [3:0] FIFO_LEVEL_RESET = 4'h0;
  localparam logic [7:0] PRECOMP_RESET = 8'h00;
  localparam logic [4:0] STEP_CODE_SPAN = 5'h10;

  // Data rate selection: multiplier of the 1 Mbps delays
  localparam logic [1:0] RATE_1M = 2'h0;
  localparam logic [1:0] RATE_500K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;

  typedef enum logic [2:0] {
    FCC_IDLE, FCC_COLLECT, FCC_RESULT, FCC_SEEK_WAIT, FCC_SEEK_PULSE
  } fcc_state_t;

  // Configuration carried as one bundle
  typedef struct packed {
    logic implied_positioning_enable;
    logic fifo_bypass;
    logic poll_disable;
    logic [3:0] fifo_level;
    logic [7:0] precomp_start;
  } fcc_config_t;

  // Specify timers bundle
  typedef struct packed {
    logic [3:0] step_interval_code;
    logic [3:0] unload_delay_code;
    logic [6:0] load_delay_code;
    logic cpu_transfer_select;
  } fcc_timing_t;

endpackage

// *** src/fcc_unit.sv ***
// Control-command unit: command decode, seek stepper, interrupt and timers
`timescale 1ns/1ps

// Summary of operation
// - Current below target: direction high, step pulses issued.
// - Current above target: direction low, step pulses issued.
// - After each step compare tracks; equal sets positioning done, ends seek.
// - Busy while seek bytes arrive, not busy during head motion.
// - Side-select bit of status zero always reads zero.
// - Leaving powerdown clears current track and all status.
// - Interrupt on data result, end of seek, and CPU-mode transfer need.
// - Sense interrupt clears interrupt, returns status zero with cause.
// - Sense interrupt with nothing pending returns 80H.
// - Cause codes: 0/11 polling, 1/00 normal, 1/01 abnormal seek end.
// - Host must sense interrupt after seek; seek interrupt held until then, busy already low.
// - Sense drive status skips execution, returns status three directly.
// - Unload delay n times 8 ms, zero is 128 ms, scaled by rate.
// - Step interval 0.5 ms per code step from code F, rate scaled.
// - Load delay n ms, code zero is 128 ms, rate scaled.
// - Transfer select 1 uses request flag and interrupt, 0 uses DMA pin.
// - Implied positioning enable seeks before each read or write.
// - FIFO bypass high requests bytes singly; defaults to one.
// - Polling enabled gives one interrupt after reset, none while head loaded.
// - FIFO level 1 to 16 bytes, code 00 one byte, default one.
// - Precompensation start track 0 to 255, default track 0.
// - Version returns one fixed byte and raises no interrupt.
module fcc_unit
  import fcc_pkg::*;
#(
  // Arbitrary neutral identity value for the version answer
  parameter logic [7:0] VERSION_BYTE = VERSION_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Command byte stream
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic result_ack,
  output logic [7:0] result_byte,
  output logic result_valid,
  output logic busy,
  // Data-path events from the read/write engine
  input wire logic data_result_enter,
  input wire logic data_exec_end,
  input wire logic data_xfer_need,
  input wire logic data_exec_start,
  input wire logic implied_seek_done,
  input wire logic [1:0] data_rate,
  input wire logic powerdown_exit,
  input wire logic [7:0] drive_status,
  // Drive interface
  output logic step_out,
  output logic dir_out,
  output logic head_loaded,
  output logic load_delay_done,
  output logic implied_seek_req,
  // Transfer signalling
  output logic master_request_flag,
  output logic dma_request_pin,
  output logic int_out,
  // Configuration view
  output fcc_config_t config_out,
  output fcc_timing_t timing_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fcc_state_t state_q;
  logic [4:0] op_q;
  logic [1:0] idx_q;
  logic [1:0] need_q;
  logic [7:0] current_track_q;
  logic [7:0] target_track_q;
  logic positioning_done_flag_q;
  logic [1:0] interrupt_code_q;
  logic seek_int_q;
  logic poll_int_q;
  logic data_int_q;
  logic xfer_int_q;
  logic [23:0] tick_q;
  logic [8:0] units_q;
  logic first_step_q;
  logic [23:0] unload_q;
  logic [23:0] load_q;
  fcc_config_t cfg_q;
  fcc_timing_t tim_q;
  logic [7:0] result_q;
  logic [7:0] status_zero;
  logic [2:0] rate_shift;
  logic [8:0] step_units;
  logic [23:0] unit_cyc;
  logic int_pending;
  logic cmd_done;

  // Delay scales with data rate: 1x, 2x, 4x
  always_comb begin
    case (data_rate)
      RATE_500K: rate_shift = 3'd1;
      RATE_250K: rate_shift = 3'd2;
      default: rate_shift = 3'd0;
    endcase
  end

  assign step_units = 9'(STEP_CODE_SPAN - {1'b0, tim_q.step_interval_code});
  assign unit_cyc = 24'(HALF_MS_CYC) << rate_shift;

  assign status_zero = {interrupt_code_q, positioning_done_flag_q, 5'h00};
  assign int_pending = seek_int_q | poll_int_q | data_int_q | xfer_int_q;
  assign cmd_done = (state_q == FCC_COLLECT) && cmd_valid && (idx_q == need_q);

  // ----------------------------------------------------------------
  // Command decoder and seek engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= FCC_IDLE;
      op_q <= 5'h00;
      idx_q <= 2'd0;
      need_q <= 2'd0;
      target_track_q <= 8'h00;
      tick_q <= 24'h000000;
      units_q <= 9'h000;
      first_step_q <= 1'b0;
      step_out <= 1'b0;
      dir_out <= 1'b0;
      result_q <= 8'h00;
    end else begin
      case (state_q)
        FCC_IDLE: begin
          if (cmd_valid) begin
            op_q <= cmd_byte[4:0];
            idx_q <= 2'd1;
            case (cmd_byte[4:0])
              OP_SPECIFY: begin
                need_q <= 2'd2;
                state_q <= FCC_COLLECT;
              end
              OP_SEEK, OP_CONFIGURE: begin
                need_q <= (cmd_byte[4:0] == OP_SEEK) ? 2'd2 : 2'd3;
                state_q <= FCC_COLLECT;
              end
              OP_SENSE_DRIVE: begin
                need_q <= 2'd1;
                state_q <= FCC_COLLECT;
              end
              OP_SENSE_INT: begin
                result_q <= int_pending ? status_zero : INVALID_STATUS;
                state_q <= FCC_RESULT;
              end
              OP_VERSION: begin
                result_q <= VERSION_BYTE;
                state_q <= FCC_RESULT;
              end
              default: begin
                result_q <= INVALID_STATUS;
                state_q <= FCC_RESULT;
              end
            endcase
          end else if (implied_seek_req && !step_out) begin
            state_q <= FCC_SEEK_WAIT;
            first_step_q <= 1'b1;
            tick_q <= 24'h000000;
            units_q <= 9'h000;
          end
        end
        FCC_COLLECT: begin
          if (cmd_valid) begin
            idx_q <= idx_q + 2'd1;
            if (op_q == OP_SEEK && idx_q == 2'd2) begin
              target_track_q <= cmd_byte;
            end
            if (idx_q == need_q) begin
              if (op_q == OP_SEEK) begin
                state_q <= FCC_SEEK_WAIT;
                first_step_q <= 1'b1;
                tick_q <= 24'h000000;
                units_q <= 9'h000;
              end else if (op_q == OP_SENSE_DRIVE) begin
                // straight to result with status three
                result_q <= drive_status;
                state_q <= FCC_RESULT;
              end else begin
                state_q <= FCC_IDLE;
              end
            end
          end
        end
        FCC_RESULT: begin
          if (result_ack) begin
            state_q <= FCC_IDLE;
          end
        end
        FCC_SEEK_WAIT: begin
          if (current_track_q == target_track_q) begin
            state_q <= FCC_IDLE;
          end else if (first_step_q || (units_q >= step_units)) begin
            dir_out <= (current_track_q < target_track_q);
            step_out <= 1'b1;
            tick_q <= 24'h000000;
            units_q <= 9'h000;
            first_step_q <= 1'b0;
            state_q <= FCC_SEEK_PULSE;
          end else if (tick_q >= unit_cyc - 24'd1) begin
            tick_q <= 24'h000000;
            units_q <= units_q + 9'd1;
          end else begin
            tick_q <= tick_q + 24'd1;
          end
        end
        FCC_SEEK_PULSE: begin
          if (tick_q >= 24'(STEP_PULSE_CYC - 1)) begin
            step_out <= 1'b0;
            state_q <= FCC_SEEK_WAIT;
          end
          tick_q <= tick_q + 24'd1;
        end
        default: state_q <= FCC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Track counter and status zero
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      current_track_q <= 8'h00;
      positioning_done_flag_q <= 1'b0;
      interrupt_code_q <= IC_NORMAL;
    end else if (powerdown_exit) begin
      current_track_q <= 8'h00;
      positioning_done_flag_q <= 1'b0;
      interrupt_code_q <= IC_NORMAL;
    end else if (state_q == FCC_SEEK_PULSE && tick_q == 24'h000000) begin
      current_track_q <= dir_out ? current_track_q + 8'd1 : current_track_q - 8'd1;
    end else if (state_q == FCC_SEEK_WAIT && current_track_q == target_track_q) begin
      positioning_done_flag_q <= 1'b1;
      interrupt_code_q <= IC_NORMAL;
    end else if (poll_int_q && !seek_int_q) begin
      positioning_done_flag_q <= 1'b0;
      interrupt_code_q <= IC_POLLING;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  logic sense_taken;
  logic poll_armed_q;
  assign sense_taken = (state_q == FCC_IDLE) && cmd_valid && (cmd_byte[4:0] == OP_SENSE_INT);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seek_int_q <= 1'b0;
      poll_int_q <= 1'b0;
      data_int_q <= 1'b0;
      xfer_int_q <= 1'b0;
      poll_armed_q <= 1'b1;
    end else begin
      // seek end held until sensed; set wins over clear
      if (state_q == FCC_SEEK_WAIT && current_track_q == target_track_q && !implied_seek_req) begin
        seek_int_q <= 1'b1;
      end else if (sense_taken || powerdown_exit) begin
        seek_int_q <= 1'b0;
      end
      // one poll interrupt after reset, not with head loaded
      if (poll_armed_q && !cfg_q.poll_disable && !head_loaded) begin
        poll_int_q <= 1'b1;
        poll_armed_q <= 1'b0;
      end else if (sense_taken || powerdown_exit) begin
        poll_int_q <= 1'b0;
      end
      if (data_result_enter) begin
        data_int_q <= 1'b1;
      end else if (cmd_valid && state_q == FCC_IDLE) begin
        data_int_q <= 1'b0;
      end
      // CPU mode flags transfer on interrupt
      xfer_int_q <= data_xfer_need && tim_q.cpu_transfer_select;
    end
  end

  // ----------------------------------------------------------------
  // Specify and configure registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tim_q <= '{STEP_CODE_RESET, UNLOAD_CODE_RESET, LOAD_CODE_RESET, 1'b0};
      cfg_q <= '{1'b0, 1'b1, 1'b0, FIFO_LEVEL_RESET, PRECOMP_RESET};
    end else if (state_q == FCC_COLLECT && cmd_valid) begin
      if (op_q == OP_SPECIFY && idx_q == 2'd1) begin
        tim_q.step_interval_code <= cmd_byte[7:4];
        tim_q.unload_delay_code <= cmd_byte[3:0];
      end
      if (op_q == OP_SPECIFY && idx_q == 2'd2) begin
        tim_q.load_delay_code <= cmd_byte[7:1];
        tim_q.cpu_transfer_select <= cmd_byte[0];
      end
      if (op_q == OP_CONFIGURE && idx_q == 2'd2) begin
        cfg_q.implied_positioning_enable <= cmd_byte[6];
        cfg_q.fifo_bypass <= cmd_byte[5];
        cfg_q.poll_disable <= cmd_byte[4];
        cfg_q.fifo_level <= cmd_byte[3:0];
      end
      if (op_q == OP_CONFIGURE && idx_q == 2'd3) begin
        cfg_q.precomp_start <= cmd_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Head load and unload timers
  // ----------------------------------------------------------------
  logic [8:0] unload_units;
  logic [8:0] load_units;
  // n times 8 ms, zero is 128 ms
  assign unload_units = (tim_q.unload_delay_code == UNLOAD_ZERO_UNITS) ? UNLOAD_ZERO_VALUE :
                        {2'b00, tim_q.unload_delay_code, 3'b000};
  // n ms, zero is 128 ms
  assign load_units = (tim_q.load_delay_code == 7'h00) ? LOAD_ZERO_VALUE :
                      {2'b00, tim_q.load_delay_code};

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      unload_q <= 24'h000000;
      load_q <= 24'h000000;
      head_loaded <= 1'b0;
      load_delay_done <= 1'b0;
      implied_seek_req <= 1'b0;
    end else begin
      if (data_exec_end) begin
        // One millisecond is two half units
        unload_q <= 24'(unload_units * 2 * unit_cyc);
      end else if (unload_q != 24'h000000) begin
        unload_q <= unload_q - 24'd1;
      end
      if (data_exec_start) begin
        head_loaded <= 1'b1;
        load_q <= 24'(load_units * 2 * unit_cyc);
        load_delay_done <= 1'b0;
        implied_seek_req <= cfg_q.implied_positioning_enable;
      end else begin
        if (load_q != 24'h000000) begin
          load_q <= load_q - 24'd1;
        end else if (head_loaded) begin
          load_delay_done <= 1'b1;
        end
        if (unload_q == 24'd1) begin
          head_loaded <= 1'b0;
        end
        if (implied_seek_done || (state_q == FCC_SEEK_WAIT &&
            current_track_q == target_track_q)) begin
          implied_seek_req <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      result_byte <= 8'h00;
      result_valid <= 1'b0;
      busy <= 1'b0;
      master_request_flag <= 1'b0;
      dma_request_pin <= 1'b0;
      int_out <= 1'b0;
      config_out <= '0;
      timing_out <= '0;
    end else begin
      result_byte <= result_q;
      result_valid <= (state_q == FCC_RESULT) && !result_ack;
      // busy in command and result phases only
      busy <= (state_q == FCC_COLLECT) || (state_q == FCC_RESULT) || cmd_done;
      master_request_flag <= (state_q != FCC_SEEK_PULSE) &&
                             (!data_xfer_need || tim_q.cpu_transfer_select);
      dma_request_pin <= data_xfer_need && !tim_q.cpu_transfer_select;
      int_out <= int_pending && !sense_taken;
      config_out <= cfg_q;
      timing_out <= tim_q;
    end
  end

endmodule // fcc_unit

// *** test/fcc_host.sv ***
// Host model that issues command bytes and takes result bytes
`timescale 1ns/1ps
module fcc_host (
  // Clock
  input wire logic ref_clk,
  // Command stream
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic result_ack,
  // Result stream
  input wire logic result_valid,
  input wire logic [7:0] result_byte
);
  logic [7:0] rq[$];

  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    result_ack = 1'b0;
  end

  // Bytes go back to back, one per clock; called just after a rising edge
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      cmd_valid = 1'b1;
      cmd_byte = b[i];
      @(posedge ref_clk);
      #1;
    end
    cmd_valid = 1'b0;
    // Idle bus shows the inverse so a stale byte cannot pass for a new one
    cmd_byte = ~cmd_byte;
  endtask

  // result bytes taken
  // Lag stalls the acknowledge to test that a result stands
  task automatic fetch(input int lag);
    int n;
    rq.delete();
    for (n = 0; n < 30; n++) begin
      if (result_valid === 1'b1) begin
        rq.push_back(result_byte);
        repeat (lag) @(posedge ref_clk);
        #1;
        result_ack = 1'b1;
        @(posedge ref_clk);
        #1;
        result_ack = 1'b0;
        n = 0;
      end
      @(posedge ref_clk);
      #1;
    end
  endtask
endmodule // fcc_host

// *** test/fcc_unit_sva.sv ***
// Port assertions for the floppy control command unit
`timescale 1ns/1ps
module fcc_unit_chk
  import fcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host side
  input wire logic result_ack,
  input wire logic result_valid,
  input wire logic [7:0] result_byte,
  input wire logic busy,
  // Drive and transfer side
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic dma_request_pin,
  input wire logic master_request_flag,
  input wire fcc_timing_t timing_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Length of the running step pulse
  int step_len_q;
  always_ff @(posedge ref_clk) begin
    step_len_q <= (step_out && reset_n) ? step_len_q + 1 : 0;
  end

  chk_step_width: assert property ($fell(step_out) |-> step_len_q == STEP_PULSE_CYC)
    else $error("step pulse width wrong");
  chk_dir_held: assert property (step_out && $past(step_out) |-> $stable(dir_out))
    else $error("direction moved during a step");
  chk_motion_idle: assert property (step_out |-> !busy)
    else $error("busy during head motion");
  chk_motion_quiet: assert property (step_out |-> !result_valid)
    else $error("result shown during head motion");
  chk_result_held: assert property (result_valid && !result_ack |=> result_valid && $stable(result_byte))
    else $error("result dropped before acknowledge");
  chk_result_busy: assert property (result_valid |-> busy)
    else $error("result phase without busy");
  chk_dma_mode: assert property (dma_request_pin |-> !timing_out.cpu_transfer_select)
    else $error("dma request in cpu mode");
  chk_flag_reset: assert property ($rose(reset_n) |-> ##[1:2] master_request_flag)
    else $error("request flag missing after reset");
endmodule // fcc_unit_chk

bind fcc_unit fcc_unit_chk fcc_unit_chk_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .result_ack(result_ack),
  .result_valid(result_valid), .result_byte(result_byte), .busy(busy),
  .step_out(step_out), .dir_out(dir_out), .dma_request_pin(dma_request_pin),
  .master_request_flag(master_request_flag), .timing_out(timing_out)
);

// *** test/test_floppy_control_command_unit.sv ***
// Testbench for the floppy control command unit
`timescale 1ns/1ps
module test_floppy_control_command_unit;
  import fcc_pkg::*;
  // Arbitrary neutral identity byte
  localparam logic [7:0] VER = 8'h3C;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, result_ack, result_valid, busy, step_out, dir_out;
  logic [7:0] cmd_byte, result_byte;
  logic data_xfer_need = 1'b0;
  logic data_result_enter = 1'b0;
  logic data_exec_start = 1'b0;
  logic head_loaded, load_delay_done, implied_seek_req;
  logic powerdown_exit = 1'b0;
  logic [1:0] data_rate = RATE_1M;
  logic [7:0] drive_status = 8'h5C;
  logic master_request_flag, dma_request_pin, int_out;
  fcc_config_t config_out;
  fcc_timing_t timing_out;
  int err_count = 0;
  int checks = 0;

  always #20 ref_clk = ~ref_clk;

  fcc_unit #(.VERSION_BYTE(VER)) fcc_unit_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .result_ack(result_ack), .result_byte(result_byte), .result_valid(result_valid),
    .busy(busy), .data_result_enter(data_result_enter), .data_exec_end(1'b0),
    .data_xfer_need(data_xfer_need), .data_exec_start(data_exec_start),
    .implied_seek_done(1'b0),
    .data_rate(data_rate), .powerdown_exit(powerdown_exit), .drive_status(drive_status),
    .step_out(step_out), .dir_out(dir_out), .head_loaded(head_loaded),
    .load_delay_done(load_delay_done),
    .implied_seek_req(implied_seek_req), .master_request_flag(master_request_flag),
    .dma_request_pin(dma_request_pin), .int_out(int_out), .config_out(config_out),
    .timing_out(timing_out)
  );

  fcc_host fcc_host_inst (
    .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .result_ack(result_ack), .result_valid(result_valid), .result_byte(result_byte)
  );

  // --------------------------------
  // Reporting
  // --------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] b[$], input int lag);
    fcc_host_inst.send(b);
    fcc_host_inst.fetch(lag);
  endtask

  task automatic sense(input logic [7:0] exp);
    cmd('{{3'h0, OP_SENSE_INT}}, 1);
    check_byte(fcc_host_inst.rq[0], exp);
  endtask

  // Waits for the interrupt level while counting fresh step pulses
  task automatic wait_int(input logic lvl, input int lim, output int steps);
    int n;
    logic prev;
    steps = 0;
    prev = step_out;
    for (n = 0; n < lim && int_out !== lvl; n++) begin
      cycles(1);
      if (step_out === 1'b1 && prev !== 1'b1) steps++;
      prev = step_out;
    end
    if (int_out !== lvl) begin
      err_count++;
      $display("[FAIL] %0t interrupt wait ran out", $time);
      end_of_test();
    end
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_poll();
    int s;
    wait_int(1'b1, 20, s);
    check_bit(config_out.implied_positioning_enable, 1'b0);
    check_bit(config_out.fifo_bypass, 1'b1);
    check_bit(config_out.poll_disable, 1'b0);
    check_byte({4'h0, config_out.fifo_level}, 8'h00);
    check_byte(config_out.precomp_start, 8'h00);
    sense(8'hC0);
    check_bit(int_out, 1'b0);
    sense(INVALID_STATUS);
  endtask

  task automatic t_info();
    cmd('{{3'h0, OP_VERSION}}, 2);
    check_byte(fcc_host_inst.rq[0], VER);
    check_bit(int_out, 1'b0);
    cmd('{{3'h0, OP_SENSE_DRIVE}, 8'h00}, 0);
    check_byte(fcc_host_inst.rq[0], 8'h5C);
    cmd('{{3'h0, OP_CONFIGURE}, 8'h00, 8'h0F, 8'hFF}, 0);
    check_bit(config_out.fifo_bypass, 1'b0);
    check_byte({4'h0, config_out.fifo_level}, 8'h0F);
    check_byte(config_out.precomp_start, 8'hFF);
  endtask

  task automatic t_specify(input logic [7:0] b2);
    cmd('{{3'h0, OP_SPECIFY}, 8'hF3, b2}, 0);
    check_byte({4'h0, timing_out.step_interval_code}, 8'h0F);
    check_byte({4'h0, timing_out.unload_delay_code}, 8'h03);
    check_byte({1'b0, timing_out.load_delay_code}, {1'b0, b2[7:1]});
    check_bit(timing_out.cpu_transfer_select, b2[0]);
  endtask

  task automatic t_seek(input logic [7:0] tgt, input logic dir, input int n, input logic fin);
    int s;
    fcc_host_inst.send('{{3'h0, OP_SEEK}, 8'h00, tgt});
    for (s = 0; s < 20000 && step_out !== 1'b1; s++) cycles(1);
    if (step_out !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t no step pulse", $time);
      end_of_test();
    end
    check_bit(dir_out, dir);
    check_bit(busy, 1'b0);
    wait_int(1'b1, 40000, s);
    check_byte(8'(s), 8'(n - 1));
    if (fin) sense(8'h20);
  endtask

  task automatic t_power();
    powerdown_exit = 1'b1;
    cycles(1);
    powerdown_exit = 1'b0;
    cycles(2);
    sense(INVALID_STATUS);
    t_seek(8'h01, 1'b1, 1, 1'b1);
  endtask

  task automatic t_xfer();
    data_xfer_need = 1'b1;
    cycles(4);
    check_bit(int_out, 1'b1);
    check_bit(dma_request_pin, 1'b0);
    check_bit(master_request_flag, 1'b1);
    t_specify(8'hFE);
    check_bit(dma_request_pin, 1'b1);
    check_bit(master_request_flag, 1'b0);
    check_bit(int_out, 1'b0);
    data_xfer_need = 1'b0;
  endtask

  task automatic t_data();
    data_result_enter = 1'b1;
    cycles(1);
    data_result_enter = 1'b0;
    cycles(1);
    check_bit(int_out, 1'b1);
    // Status zero still holds the last normal seek end
    sense(8'h20);
    check_bit(int_out, 1'b0);
  endtask

  task automatic t_load();
    t_specify(8'h03);
    data_rate = RATE_500K;
    data_exec_start = 1'b1;
    cycles(1);
    data_exec_start = 1'b0;
    check_bit(head_loaded, 1'b1);
    check_bit(implied_seek_req, 1'b0);
    // Code 01 at 500 Kbps is 2 ms, 50000 cycles of 40 ns
    cycles(50000);
    check_bit(load_delay_done, 1'b0);
    cycles(1);
    check_bit(load_delay_done, 1'b1);
    data_rate = RATE_1M;
  endtask

  initial begin
    cycles(8);
    reset_n = 1'b1;
    t_poll();
    t_info();
    t_specify(8'hFF);
    t_seek(8'h02, 1'b1, 2, 1'b1);
    t_seek(8'h01, 1'b0, 1, 1'b0);
    t_power();
    t_xfer();
    t_data();
    t_load();
    end_of_test();
  end
endmodule // test_floppy_control_command_unit
